/* verilog/sbsc_sideband.sv */
`timescale 1ns/1ps

module sbsc_sideband
  import sbsc_pkg::*;
(
  // Primary clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration and power state
  input wire logic sec_reset_bit,
  input wire logic [NUM_CLK-1:0] clk_disable_cfg,
  input wire logic d3hot,
  input wire logic test_mode,
  // Straps and mode pins
  input wire logic sec_central_func_n,
  input wire logic bus_power_clock_strap,
  input wire logic speed_strap,
  input wire logic mode_select_0,
  input wire logic mode_select_1,
  // Capability pins
  input wire logic pri_fast_capable,
  input wire logic sec_fast_capable_in,
  output logic sec_fast_capable_out,
  output logic sec_fast_capable_oe,
  // Clock outputs and serial mask
  input wire logic clock_mask_serial_in,
  output logic [NUM_CLK-1:0] sec_clock_outputs,
  output logic sec_reset_n,
  // Primary status
  output logic internal_arbiter,
  output logic sec_bus_fast,
  output logic scan_shift_en,
  output logic scan_capture,
  output logic compat_mode,
  output logic mode_reserved,
  output logic sec_system_err,
  output logic mask_loaded,
  output logic [NUM_CLK-1:0] clock_mask,
  // Secondary clock and engine handshake
  input wire logic sec_clock_feedback,
  input wire logic sec_bus_idle,
  input wire logic bridge_req,
  input wire logic parity_err_det,
  output logic bridge_gnt,
  // Secondary pins
  input wire logic [NUM_REQ-1:0] sec_req_n,
  output logic [NUM_REQ-1:0] sec_gnt_n,
  output logic [NUM_REQ-1:0] sec_gnt_oe,
  input wire logic sec_system_err_n,
  output logic sec_parity_err_n,
  output logic sec_parity_err_oe,
  output sbsc_drive_t sec_bus_drive
);

  // ---------------- Primary domain ----------------

  sbsc_strap_t strap_s1;
  sbsc_strap_t strap_s2;
  sbsc_strap_t strap_q;
  logic cap_done_q;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic serr_m1;
  logic serr_m2;

  // Pins pass two flops; straps are then caught once after release
  always_ff @(posedge mclk) begin
    strap_s1 <= {sec_central_func_n, bus_power_clock_strap, speed_strap,
                 mode_select_0, mode_select_1};
    strap_s2 <= strap_s1;
    pin_s1 <= {pri_fast_capable, sec_fast_capable_in, clock_mask_serial_in};
    pin_s2 <= pin_s1;
  end

  wire pri_fast_s = pin_s2[2];
  wire sec_fast_s = pin_s2[1];
  wire mask_bit_s = pin_s2[0];

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      strap_q <= STRAP_RST;
      cap_done_q <= 1'b0;
    end else if (!cap_done_q) begin
      strap_q <= strap_s2;
      cap_done_q <= 1'b1;
    end
  end

  // Serial clock mask, first bit received ends in the top bit
  sbsc_msk_state_t msk_state_q;
  logic [3:0] msk_cnt_q;
  logic [NUM_CLK-1:0] mask_q;

  wire msk_shift = (msk_state_q == MSK_SHIFT);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      msk_state_q <= MSK_SHIFT;
      msk_cnt_q <= 4'h0;
      mask_q <= CLK_NONE;
    end else if (msk_shift) begin
      mask_q <= {mask_q[NUM_CLK-2:0], mask_bit_s};
      msk_cnt_q <= msk_cnt_q + 4'h1;
      if (msk_cnt_q == MASK_LAST) begin
        msk_state_q <= MSK_DONE;
      end
    end
  end

  // Secondary reset is stretched over the shift so the mask can load
  wire sec_rst_req = sec_reset_bit | msk_shift;
  logic sec_rst_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sec_rst_q <= 1'b1;
    end else begin
      sec_rst_q <= sec_rst_req;
    end
  end

  assign sec_reset_n = ~sec_rst_q;

  // Clock gating
  wire b2_active = strap_q.bus_power_clock & d3hot;
  wire [NUM_CLK-1:0] mask_eff = msk_shift ? CLK_NONE : mask_q;
  wire mask_all_high = ~msk_shift & (mask_q == CLK_ALL);
  wire [NUM_CLK-1:0] clk_off = clk_disable_cfg | mask_eff;
  wire [NUM_CLK-1:0] clk_en_d =
    ~clk_off & {NUM_CLK{~b2_active & ~mask_all_high}};
  wire force_high_d = mask_all_high & ~b2_active;

  logic [NUM_CLK-1:0] clk_en_q;
  logic force_high_q;

  // Enables change on the falling edge so the gated clock never glitches
  always_ff @(negedge mclk) begin
    if (!rst_n) begin
      clk_en_q <= CLK_ALL;
      force_high_q <= 1'b0;
    end else begin
      clk_en_q <= clk_en_d;
      force_high_q <= force_high_d;
    end
  end

  assign sec_clock_outputs =
    ({NUM_CLK{mclk}} & clk_en_q) | {NUM_CLK{force_high_q}};

  // Capability, speed and mode reporting
  logic fast_oe_q;
  logic bus_fast_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fast_oe_q <= 1'b0;
      bus_fast_q <= 1'b0;
    end else begin
      fast_oe_q <= ~pri_fast_s;
      bus_fast_q <= ~test_mode & strap_q.speed & sec_fast_s &
                    pri_fast_s;
    end
  end

  assign sec_fast_capable_out = 1'b0;
  assign sec_fast_capable_oe = fast_oe_q;
  assign sec_bus_fast = bus_fast_q;
  // Scan control follows the live pin, not the caught strap
  assign scan_shift_en = test_mode & ~strap_s2.speed;
  assign scan_capture = test_mode & strap_s2.speed;
  assign compat_mode = strap_q.mode0;
  assign mode_reserved = ~strap_q.mode0;
  assign internal_arbiter = ~strap_q.central_func_n;
  assign mask_loaded = ~msk_shift;
  assign clock_mask = mask_q;

  // ---------------- Secondary domain ----------------

  logic [NUM_REQ-1:0] req_s1;
  logic [NUM_REQ-1:0] req_s2;
  logic serr_s1;
  logic serr_s2;
  logic rst_s1;
  logic rst_s2;
  logic cfn_s1;
  logic cfn_s2;

  always_ff @(posedge sec_clock_feedback) begin
    req_s1 <= sec_req_n;
    req_s2 <= req_s1;
    serr_s1 <= sec_system_err_n;
    serr_s2 <= serr_s1;
    rst_s1 <= sec_rst_q;
    rst_s2 <= rst_s1;
    cfn_s1 <= strap_q.central_func_n;
    cfn_s2 <= cfn_s1;
  end

  // System error level back into the primary domain
  always_ff @(posedge mclk) begin
    serr_m1 <= ~serr_s2;
    serr_m2 <= serr_m1;
  end

  assign sec_system_err = serr_m2;

  wire s_rst = rst_s2;
  wire ext_mode = cfn_s2;
  wire [NUM_ARB-1:0] req_vec = {bridge_req, ~req_s2};

  // Rotating priority, starting after the last owner
  function automatic logic [3:0] rr_pick(input logic [NUM_ARB-1:0] r,
                                         input logic [3:0] last);
    logic [3:0] sel;
    int idx;
    sel = BRIDGE_IDX;
    for (int k = NUM_ARB; k >= 1; k--) begin
      idx = (int'(last) + k) % NUM_ARB;
      if (r[idx]) begin
        sel = 4'(idx);
      end
    end
    return sel;
  endfunction

  sbsc_arb_state_t arb_q;
  logic [3:0] owner_q;
  logic [1:0] gap_q;
  logic [NUM_REQ-1:0] gnt_q;

  wire [3:0] next_owner = rr_pick(req_vec, owner_q);
  // An idle bus with nobody asking stays parked on the bridge
  wire owner_release = sec_bus_idle & ~req_vec[owner_q] &
                       ((owner_q != BRIDGE_IDX) | (|req_vec));
  wire gap_done = (gap_q == (GNT_GAP_CYC - 2'h1));

  always_ff @(posedge sec_clock_feedback) begin
    if (s_rst | ext_mode) begin
      arb_q <= ARB_GRANT;
      owner_q <= BRIDGE_IDX;
      gap_q <= 2'h0;
    end else begin
      unique case (arb_q)
        ARB_GRANT: begin
          if (owner_release) begin
            arb_q <= ARB_GAP;
            gap_q <= 2'h0;
          end
        end
        ARB_GAP: begin
          gap_q <= gap_q + 2'h1;
          if (gap_done) begin
            arb_q <= ARB_GRANT;
            owner_q <= next_owner;
          end
        end
      endcase
    end
  end

  logic [NUM_REQ-1:0] gnt_int;

  for (genvar i = 0; i < NUM_REQ; i++) begin : g_gnt
    assign gnt_int[i] = ~((arb_q == ARB_GRANT) && (owner_q == 4'(i)));

    chk_gnt_gap: assert property (
      @(posedge sec_clock_feedback) disable iff (s_rst || ext_mode)
      $rose(sec_gnt_n[i]) |=> sec_gnt_n[i])
      else $error("grant re-asserted too soon");
  end

  wire [NUM_REQ-1:0] gnt_ext = {GNT_IDLE[NUM_REQ-1:1], ~bridge_req};
  wire [NUM_REQ-1:0] gnt_d = ext_mode ? gnt_ext : gnt_int;

  always_ff @(posedge sec_clock_feedback) begin
    if (s_rst) begin
      gnt_q <= GNT_IDLE;
    end else begin
      gnt_q <= gnt_d;
    end
  end

  assign sec_gnt_n = gnt_q;
  assign sec_gnt_oe = {NUM_REQ{~s_rst}};
  wire int_bridge_gnt = (arb_q == ARB_GRANT) && (owner_q == BRIDGE_IDX);
  assign bridge_gnt = ext_mode ? ~req_s2[EXT_REQ_BIT] : int_bridge_gnt;

  // Parity error pin: low while errors arrive, one high cycle, then float
  logic perr_low_q;
  logic perr_hi_q;

  always_ff @(posedge sec_clock_feedback) begin
    if (s_rst) begin
      perr_low_q <= 1'b0;
      perr_hi_q <= 1'b0;
    end else begin
      perr_low_q <= parity_err_det;
      perr_hi_q <= perr_low_q & ~parity_err_det;
    end
  end

  assign sec_parity_err_n = ~perr_low_q;
  assign sec_parity_err_oe = (perr_low_q | perr_hi_q) & ~s_rst;

  wire park = sec_bus_idle & bridge_gnt;
  assign sec_bus_drive.ad_oe = s_rst | park;
  assign sec_bus_drive.cbe_oe = s_rst | park;
  assign sec_bus_drive.par_oe = s_rst | park;
  assign sec_bus_drive.drive_zero = s_rst;

  // ---------------- Checks ----------------

  sequence s_mask_busy;
    msk_shift [*8];
  endsequence

  chk_mask_shift: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> s_mask_busy ##1 msk_shift ##1 msk_shift ##1 !msk_shift)
    else $error("mask shift length wrong");

  chk_sreset_bit: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (sec_reset_bit || msk_shift) |=> !sec_reset_n)
    else $error("secondary reset not asserted");

  chk_fast_drive: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !pri_fast_s ##1 !pri_fast_s |-> sec_fast_capable_oe && !sec_fast_capable_out)
    else $error("fast capability not pulled low");

  chk_b2_stop: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $past(b2_active) && b2_active |-> clk_en_q == CLK_NONE && !force_high_q)
    else $error("clocks running in low power state");

  chk_clk_all_en: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $past(!b2_active && mask_loaded && clk_disable_cfg == CLK_NONE) &&
    !b2_active && mask_loaded && clk_disable_cfg == CLK_NONE &&
    mask_q == CLK_NONE |-> clk_en_q == CLK_ALL)
    else $error("clock disabled with empty mask");

  chk_perr_assert: assert property (
    @(posedge sec_clock_feedback) disable iff (s_rst)
    parity_err_det |=> sec_parity_err_oe && !sec_parity_err_n)
    else $error("parity error not driven");

  chk_perr_release: assert property (
    @(posedge sec_clock_feedback) disable iff (s_rst)
    $fell(sec_parity_err_oe) |-> $past(sec_parity_err_n))
    else $error("parity error released without high cycle");

  chk_park_drive: assert property (
    @(posedge sec_clock_feedback) disable iff (s_rst)
    sec_bus_idle && bridge_gnt |-> sec_bus_drive.ad_oe &&
    sec_bus_drive.cbe_oe && sec_bus_drive.par_oe)
    else $error("parked bus not driven");

  chk_reset_float: assert property (
    @(posedge sec_clock_feedback)
    s_rst |-> sec_gnt_oe == '0 && !sec_parity_err_oe &&
    sec_bus_drive.drive_zero && sec_bus_drive.ad_oe)
    else $error("bus not quiet during secondary reset");

  chk_ext_request: assert property (
    @(posedge sec_clock_feedback) disable iff (s_rst)
    ext_mode && $past(ext_mode && !s_rst) |->
    sec_gnt_n[EXT_REQ_BIT] == !$past(bridge_req))
    else $error("request output does not follow bridge request");

endmodule // sbsc_sideband

/* common/sbsc_pkg.sv */
package sbsc_pkg;

  // Secondary bus sizing
  localparam int NUM_REQ = 9;
  localparam int NUM_CLK = 10;
  localparam int NUM_ARB = NUM_REQ + 1;

  // Arbiter slot of the bridge itself, after the nine external agents
  localparam logic [3:0] BRIDGE_IDX = 4'h9;

  // Grant pin reused as the bridge's own request in external mode
  localparam int EXT_REQ_BIT = 0;

  // Idle cycles on every grant pin between two grants
  localparam logic [1:0] GNT_GAP_CYC = 2'h2;

  // Serial clock-mask length, last count of the shift
  localparam logic [3:0] MASK_LAST = 4'h9;

  // Reset and idle values
  localparam logic [NUM_REQ-1:0] GNT_IDLE = 9'h1FF;
  localparam logic [NUM_CLK-1:0] CLK_ALL = 10'h3FF;
  localparam logic [NUM_CLK-1:0] CLK_NONE = 10'h000;

  typedef enum logic {
    ARB_GRANT,
    ARB_GAP
  } sbsc_arb_state_t;

  typedef enum logic {
    MSK_SHIFT,
    MSK_DONE
  } sbsc_msk_state_t;

  typedef struct packed {
    logic central_func_n;
    logic bus_power_clock;
    logic speed;
    logic mode0;
    logic mode1;
  } sbsc_strap_t;

  // Internal arbiter, no power clock control, 33 MHz, compatible mode
  localparam sbsc_strap_t STRAP_RST = 5'h02;

  typedef struct packed {
    logic ad_oe;
    logic cbe_oe;
    logic par_oe;
    logic drive_zero;
  } sbsc_drive_t;

endpackage

/* tb/sbsc_agent_model.sv */
`timescale 1ns/1ps

// Secondary agents; a released request line is driven high at the falling clock edge
module sbsc_agent_model
  import sbsc_pkg::*;
(
  // Secondary clock
  input wire logic clk,
  // Commands from the bench and grant pins
  input wire logic [NUM_REQ-1:0] want,
  input wire logic [NUM_REQ-1:0] sec_gnt_n,
  // Request pins and spacing flag
  output logic [NUM_REQ-1:0] sec_req_n,
  output logic gap_bad
);
  logic [NUM_REQ-1:0] gnt_q;
  logic [1:0] gap_q [NUM_REQ];

  initial begin
    sec_req_n = GNT_IDLE;
    gnt_q = GNT_IDLE;
    gap_bad = 1'b0;
    for (int i = 0; i < NUM_REQ; i++) gap_q[i] = GNT_GAP_CYC;
  end

  always @(negedge clk) sec_req_n <= ~want;

  // Count idle cycles on each grant pin before it falls again
  always @(posedge clk) begin
    for (int i = 0; i < NUM_REQ; i++) begin
      if (!sec_gnt_n[i] && gnt_q[i] && gap_q[i] < GNT_GAP_CYC) gap_bad <= 1'b1;
      if (!sec_gnt_n[i]) gap_q[i] <= 2'h0;
      else if (gap_q[i] < GNT_GAP_CYC) gap_q[i] <= gap_q[i] + 2'h1;
    end
    gnt_q <= sec_gnt_n;
  end
endmodule // sbsc_agent_model

/* tb/test_secondary_bus_sideband_control.sv */
`timescale 1ns/1ps

module test_secondary_bus_sideband_control;
  import sbsc_pkg::*;
  logic mclk = 1'b0, sclk = 1'b0, rst_n = 1'b0, sec_reset_bit = 1'b0;
  logic d3hot = 1'b0, test_mode = 1'b0, sec_central_func_n = 1'b0;
  logic bus_power_clock_strap = 1'b0, speed_strap = 1'b0;
  logic mode_select_0 = 1'b1, mode_select_1 = 1'b0, pri_fast_capable = 1'b1;
  logic fc_ext = 1'b1, clock_mask_serial_in = 1'b0, sec_bus_idle = 1'b1;
  logic bridge_req = 1'b0, parity_err_det = 1'b0, sec_system_err_n = 1'b1;
  logic [9:0] clk_disable_cfg = 10'h000;
  logic [8:0] want = 9'h000;
  logic sec_fast_capable_in, sec_fast_capable_out, sec_fast_capable_oe;
  logic sec_reset_n, internal_arbiter, sec_bus_fast, scan_shift_en, gap_bad;
  logic scan_capture, compat_mode, mode_reserved, sec_system_err;
  logic mask_loaded, bridge_gnt, sec_parity_err_n, sec_parity_err_oe;
  logic [9:0] sec_clock_outputs, clock_mask;
  logic [8:0] sec_req_n, sec_gnt_n, sec_gnt_oe;
  sbsc_drive_t sec_bus_drive;
  int failures = 0, compares = 0, n;

  always #50 mclk = ~mclk;
  // Offset keeps the feedback clock out of step with mclk
  always begin
    if ($time == 0) #3.1;
    #7.5 sclk = ~sclk;
  end
  // Open-drain wire: pulled up unless a party sinks it
  assign sec_fast_capable_in = sec_fast_capable_oe ? sec_fast_capable_out
                                                   : fc_ext;

  sbsc_sideband i_sbsc_sideband (
    .mclk, .rst_n, .sec_reset_bit, .clk_disable_cfg, .d3hot, .test_mode,
    .sec_central_func_n, .bus_power_clock_strap, .speed_strap,
    .mode_select_0, .mode_select_1, .pri_fast_capable,
    .sec_fast_capable_in, .sec_fast_capable_out, .sec_fast_capable_oe,
    .clock_mask_serial_in, .sec_clock_outputs, .sec_reset_n,
    .internal_arbiter, .sec_bus_fast, .scan_shift_en, .scan_capture,
    .compat_mode, .mode_reserved, .sec_system_err, .mask_loaded,
    .clock_mask, .sec_clock_feedback(sclk), .sec_bus_idle, .bridge_req,
    .parity_err_det, .bridge_gnt, .sec_req_n, .sec_gnt_n, .sec_gnt_oe,
    .sec_system_err_n, .sec_parity_err_n, .sec_parity_err_oe, .sec_bus_drive
  );

  sbsc_agent_model i_sbsc_agent_model (
    .clk(sclk), .want, .sec_gnt_n, .sec_req_n, .gap_bad
  );

  task automatic check(input string w, input logic [9:0] e, g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk1(input string w, input logic e, g);
    check(w, {9'h000, e}, {9'h000, g});
  endtask

  task automatic clks(input logic [9:0] hi, lo);
    @(posedge mclk);
    #20;
    check("clocks high", hi, sec_clock_outputs);
    @(negedge mclk);
    #20;
    check("clocks low", lo, sec_clock_outputs);
  endtask

  task automatic do_reset(input logic [9:0] pat);
    rst_n = 1'b0;
    repeat (10) @(negedge mclk);
    chk1("sec_reset_n", 1'b0, sec_reset_n);
    // Mask bits lead the shift by two edges through the synchronizer
    for (int i = 9; i >= 0; i--) begin
      @(negedge mclk);
      clock_mask_serial_in = pat[i];
      if (i == 7) rst_n = 1'b1;
    end
    for (n = 0; n < 30 && sec_reset_n !== 1'b1; n++) @(negedge mclk);
    check("clock_mask", pat, clock_mask);
    chk1("mask_loaded", 1'b1, mask_loaded);
    repeat (10) @(negedge sclk);
  endtask

  task automatic t_mask;
    do_reset(10'h2C5);
    clk_disable_cfg = 10'h00F;
    // Enables only move on the falling edge
    @(negedge mclk);
    clks(~10'h2CF, 10'h000);
    d3hot = 1'b1;
    repeat (2) @(negedge mclk);
    clks(~10'h2CF, 10'h000);
    chk1("internal_arbiter", 1'b1, internal_arbiter);
    chk1("compat_mode", 1'b1, compat_mode);
    chk1("sec_bus_fast", 1'b0, sec_bus_fast);
    d3hot = 1'b0;
    clk_disable_cfg = 10'h000;
    $display("test mask done");
  endtask

  task automatic t_b2;
    bus_power_clock_strap = 1'b1;
    do_reset(10'h3FF);
    clks(10'h3FF, 10'h3FF);
    d3hot = 1'b1;
    repeat (3) @(negedge mclk);
    clks(10'h000, 10'h000);
    d3hot = 1'b0;
    bus_power_clock_strap = 1'b0;
    $display("test power done");
  endtask

  task automatic t_ext;
    sec_central_func_n = 1'b1;
    speed_strap = 1'b1;
    mode_select_0 = 1'b0;
    mode_select_1 = 1'b1;
    do_reset(10'h000);
    clks(10'h3FF, 10'h000);
    chk1("internal_arbiter", 1'b0, internal_arbiter);
    chk1("mode_reserved", 1'b1, mode_reserved);
    chk1("sec_bus_fast", 1'b1, sec_bus_fast);
    @(negedge sclk) bridge_req = 1'b1;
    repeat (2) @(negedge sclk);
    chk1("gnt0 as request", 1'b0, sec_gnt_n[0]);
    want[0] = 1'b1;
    for (n = 0; n < 10 && bridge_gnt !== 1'b1; n++) @(negedge sclk);
    chk1("req0 as grant", 1'b1, bridge_gnt);
    bridge_req = 1'b0;
    want = 9'h000;
    fc_ext = 1'b0;
    repeat (5) @(negedge mclk);
    chk1("sec_bus_fast", 1'b0, sec_bus_fast);
    fc_ext = 1'b1;
    pri_fast_capable = 1'b0;
    repeat (5) @(negedge mclk);
    chk1("fast oe", 1'b1, sec_fast_capable_oe);
    chk1("fast wire", 1'b0, sec_fast_capable_in);
    pri_fast_capable = 1'b1;
    test_mode = 1'b1;
    speed_strap = 1'b0;
    repeat (4) @(negedge mclk);
    chk1("scan_shift_en", 1'b1, scan_shift_en);
    speed_strap = 1'b1;
    repeat (4) @(negedge mclk);
    chk1("scan_capture", 1'b1, scan_capture);
    chk1("sec_bus_fast", 1'b0, sec_bus_fast);
    test_mode = 1'b0;
    {sec_central_func_n, speed_strap, mode_select_0} = 3'b001;
    $display("test external done");
  endtask

  task automatic t_arb;
    do_reset(10'h000);
    chk1("bridge parked", 1'b1, bridge_gnt);
    check("park drive", 10'h00E, {6'h00, sec_bus_drive});
    check("gnt oe", 10'h1FF, {1'b0, sec_gnt_oe});
    @(negedge sclk) sec_bus_idle = 1'b0;
    @(negedge sclk);
    check("busy no park", 10'h000, {6'h00, sec_bus_drive});
    sec_bus_idle = 1'b1;
    @(negedge sclk) want[3] = 1'b1;
    for (n = 0; n < 30 && sec_gnt_n[3] !== 1'b0; n++) @(negedge sclk);
    chk1("gnt3", 1'b0, sec_gnt_n[3]);
    check("agent drive", 10'h000, {6'h00, sec_bus_drive});
    // A busy bus keeps the owner even after its request is gone
    sec_bus_idle = 1'b0;
    want = 9'h020;
    repeat (8) @(negedge sclk);
    chk1("busy owner kept", 1'b0, sec_gnt_n[3]);
    sec_bus_idle = 1'b1;
    for (n = 0; n < 30 && sec_gnt_n[5] !== 1'b0; n++) @(negedge sclk);
    chk1("gnt5", 1'b0, sec_gnt_n[5]);
    want = 9'h000;
    for (n = 0; n < 30 && bridge_gnt !== 1'b1; n++) @(negedge sclk);
    chk1("grant spacing", 1'b0, gap_bad);
    $display("test arbiter done");
  endtask

  task automatic t_err;
    @(negedge sclk) parity_err_det = 1'b1;
    @(posedge sclk) #1;
    check("perr", 10'h001, {8'h00, sec_parity_err_n, sec_parity_err_oe});
    @(negedge sclk) parity_err_det = 1'b0;
    @(posedge sclk) #1;
    check("perr", 10'h003, {8'h00, sec_parity_err_n, sec_parity_err_oe});
    @(posedge sclk) #1;
    chk1("perr oe", 1'b0, sec_parity_err_oe);
    @(negedge sclk) sec_system_err_n = 1'b0;
    for (n = 0; n < 10 && sec_system_err !== 1'b1; n++) @(negedge mclk);
    chk1("sec_system_err", 1'b1, sec_system_err);
    @(negedge sclk) sec_system_err_n = 1'b1;
    for (n = 0; n < 10 && sec_system_err !== 1'b0; n++) @(negedge mclk);
    chk1("sec_system_err", 1'b0, sec_system_err);
    @(negedge mclk) sec_reset_bit = 1'b1;
    repeat (10) @(negedge mclk);
    chk1("sec_reset_n", 1'b0, sec_reset_n);
    check("reset drive", 10'h00F, {6'h00, sec_bus_drive});
    check("gnt oe", 10'h000, {1'b0, sec_gnt_oe});
    sec_reset_bit = 1'b0;
    for (n = 0; n < 30 && sec_reset_n !== 1'b1; n++) @(negedge mclk);
    chk1("sec_reset_n", 1'b1, sec_reset_n);
    $display("test errors done");
  endtask

  task automatic print_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #500000;
    failures++;
    $display("CHECK FAILED watchdog expected end seen hang");
    print_verdict();
  end

  initial begin
    t_mask();
    t_b2();
    t_ext();
    t_arb();
    t_err();
    print_verdict();
  end
endmodule // test_secondary_bus_sideband_control
